// ---- csd_regbank.sv ----
// Card specific data register, version 2 layout, with write/erase gate
`timescale 1ns/1ps
`include "csd_cfg.svh"
module csd_regbank
    import csd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Write and erase command gate
    input  wire logic        cmd_valid,
    input  wire logic        cmd_erase,
    input  wire logic [11:0] cmd_len,
    output logic             cmd_done,
    output logic             cmd_ok,
    // Register image and lock state
    output csd_word_t        card_specific_data,
    output logic             write_locked
);

    function automatic logic [6:0] crc7_calc(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c  = {c[5:3], c[2] ^ fb, c[1:0], fb};
        end
        return c;
    endfunction

    // Count encoded as value minus one
    function automatic logic [7:0] units_of(input logic [6:0] code);
        return {1'b0, code} + 8'h01;
    endfunction

    function automatic logic [5:0] speed_multiple(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h00;
        if (code <= 3'h5) begin
            m = 6'h01 << code;
        end
        return m;
    endfunction

    function automatic logic block_code_valid(input logic [3:0] code);
        return (code >= 4'h9) && (code <= 4'hb);
    endfunction

    // State
    csd_rate_t   rate_reg;
    logic        copy_reg;
    logic        perm_reg;
    logic        temp_reg;
    logic [6:0]  crc_reg;
    logic        crc_auto_reg;
    logic [31:0] rdata_reg;
    logic        done_reg;
    logic        ok_reg;
    csd_word_t   image_reg;
    logic        image_valid_reg;

    // Decode
    wire         wr_word0   = reg_wr && (reg_addr == `CSD_OFS_WORD0);
    wire         wr_ctrl    = reg_wr && (reg_addr == `CSD_OFS_CTRL);
    wire         rom_card   = `CSD_READ_ONLY_CARD;
    wire         copy_set   = wr_word0 && !rom_card && reg_wdata[`CSD_BIT_COPY];
    wire         perm_set   = wr_word0 && reg_wdata[`CSD_BIT_PERM];
    wire         locked     = perm_reg || temp_reg;

    logic [7:0]  rate_code;
    always_comb begin
        unique case (rate_reg)
            CSD_RATE_25M:  rate_code = `CSD_RATE_DEFAULT;
            CSD_RATE_50M:  rate_code = `CSD_RATE_HIGH;
            CSD_RATE_100M: rate_code = `CSD_RATE_FAST;
            CSD_RATE_200M: rate_code = `CSD_RATE_FASTEST;
        endcase
    end

    // Fixed fields are constants; reserved slices are zero
    wire [119:0] body = {
        `CSD_LAYOUT_V2, 6'h00,
        `CSD_ACCESS_TIME, `CSD_ACCESS_CYCLES,
        rate_code,
        `CSD_CMD_CLASSES, `CSD_READ_BLK_CODE,
        3'h0, `CSD_DRIVER_STAGE, 6'h00,
        `CSD_DEVICE_SIZE, 1'h0,
        `CSD_SINGLE_ERASE, `CSD_SECTOR_CODE,
        `CSD_GROUP_CODE, `CSD_GROUP_ALLOWED, 2'h0,
        `CSD_SPEED_CODE, `CSD_WRITE_BLK_CODE,
        `CSD_SMALL_WRITE, 5'h00,
        `CSD_FORMAT_FAMILY,
        copy_reg, perm_reg, temp_reg,
        `CSD_FORMAT_CODE, 2'h0
    };

    // Until software writes a checksum, it tracks the contents
    wire [6:0]   crc_live   = crc_auto_reg ? crc7_calc(body) : crc_reg;
    wire [127:0] image      = {body, crc_live, 1'b1};

    // Block size check
    wire [3:0]   wr_code    = image[25:22];
    wire         small_ok   = image[21];
    wire [12:0]  max_len    = 13'h0001 << wr_code;
    wire         len_in     = ({1'b0, cmd_len} <= max_len) && (cmd_len != 12'h000);
    wire         len_step   = (cmd_len[8:0] == 9'h000);
    wire         len_ok     = len_in && (small_ok || len_step);
    wire         is_512     = (cmd_len == `CSD_BLOCK_UNIT);
    wire         cmd_pass   = !locked && (cmd_erase || len_ok || is_512);

    // Status word
    wire [31:0]  stat_word  = {8'h00, units_of(image[45:39]), 2'h0,
                               speed_multiple(image[28:26]),
                               4'h0, block_code_valid(wr_code), perm_reg, copy_reg, locked};

    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `CSD_OFS_WORD0: rd_mux = image[31:0];
            `CSD_OFS_WORD1: rd_mux = image[63:32];
            `CSD_OFS_WORD2: rd_mux = image[95:64];
            `CSD_OFS_WORD3: rd_mux = image[127:96];
            `CSD_OFS_CTRL:  rd_mux = {30'h0, rate_reg};
            `CSD_OFS_STAT:  rd_mux = stat_word;
            default:        rd_mux = 32'h0;
        endcase
    end

    wire [31:0]  rdata_next = reg_rd ? rd_mux : 32'h0;

    // Once-bits only move from zero to one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            copy_reg <= 1'b0;
            perm_reg <= 1'b0;
        end else begin
            if (copy_set) begin
                copy_reg <= 1'b1;
            end
            if (perm_set) begin
                perm_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_reg     <= 1'b0;
            crc_reg      <= 7'h00;
            crc_auto_reg <= 1'b1;
        end else if (wr_word0) begin
            temp_reg     <= reg_wdata[`CSD_BIT_TEMP];
            crc_reg      <= reg_wdata[`CSD_CRC_HI:`CSD_CRC_LO];
            crc_auto_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_reg <= CSD_RATE_25M;
        end else if (wr_ctrl) begin
            rate_reg <= csd_rate_t'(reg_wdata[1:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0;
            done_reg  <= 1'b0;
            ok_reg    <= 1'b0;
            image_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
            done_reg  <= cmd_valid;
            ok_reg    <= cmd_valid && cmd_pass;
            image_reg <= image;
        end
    end

    // Image port holds reset zeros until the first edge after release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            image_valid_reg <= 1'b0;
        end else begin
            image_valid_reg <= 1'b1;
        end
    end

    assign reg_rdata          = rdata_reg;
    assign cmd_done           = done_reg;
    assign cmd_ok             = ok_reg;
    assign card_specific_data = image_reg;
    assign write_locked       = locked;

    fixed_access_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[119:104] == {`CSD_ACCESS_TIME, `CSD_ACCESS_CYCLES}))
        else $error("Access time fields not fixed");

    rate_code_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_ctrl |-> ##2 (card_specific_data[103:96] inside {8'h32, 8'h5a, 8'h0b, 8'h2b}))
        else $error("Transfer rate code not permitted");

    rate_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_ctrl && reg_wdata[1:0] == 2'h1) |-> ##2 (card_specific_data[103:96] == 8'h5a))
        else $error("Rate select not reflected");

    block_code_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[25:22] == 4'h9 && card_specific_data[83:80] == 4'h9
             && card_specific_data[21] == 1'b0))
        else $error("Block length fields wrong");

    erase_fields_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[46:39] == 8'hff && card_specific_data[31] == 1'b0))
        else $error("Erase or group fields wrong");

    perm_sticky_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        perm_reg |=> perm_reg [*8])
        else $error("Permanent lock cleared");

    copy_sticky_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        copy_reg |=> copy_reg)
        else $error("Copy flag cleared");

    lock_refuse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && (perm_reg || temp_reg)) |=> (cmd_done && !cmd_ok))
        else $error("Locked card accepted a command");

    block512_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && !locked && cmd_len == 12'h200) |=> (cmd_done && cmd_ok))
        else $error("512-byte write refused");

    small_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && !cmd_erase && cmd_len[8:0] != 9'h000) |=> !cmd_ok)
        else $error("Small write accepted");

    temp_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_word0 |=> (write_locked == ($past(reg_wdata[12]) || perm_reg)))
        else $error("Temporary lock write lost");

    crc_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_word0 |-> ##2 (card_specific_data[7:1] == $past(reg_wdata[7:1], 2)))
        else $error("Written checksum not kept");

    layout_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[127:120] == {`CSD_LAYOUT_V2, 6'h00}))
        else $error("Layout version field wrong");

    size_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[95:84] == `CSD_CMD_CLASSES
            && card_specific_data[69:48] == `CSD_DEVICE_SIZE && card_specific_data[76] == `CSD_DRIVER_STAGE))
        else $error("Class, size or driver fields wrong");

    group_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[38:31] == 8'h00))
        else $error("Protect group fields wrong");

    speed_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[28:26] == `CSD_SPEED_CODE))
        else $error("Write speed field wrong");

    block_equal_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[25:22] == card_specific_data[83:80]))
        else $error("Write and read block codes differ");

    block_range_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[25:22] inside {4'h9, 4'ha, 4'hb}))
        else $error("Write block code reserved");

    format_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> (card_specific_data[15] == 1'b0 && card_specific_data[11:10] == 2'h0))
        else $error("File format fields wrong");

    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        image_valid_reg |-> ({card_specific_data[125:120], card_specific_data[79:77], card_specific_data[75:70],
            card_specific_data[47], card_specific_data[30:29], card_specific_data[20:16], card_specific_data[9:8]}
            == 25'h0 && card_specific_data[0]))
        else $error("Reserved bits not fixed");

    perm_rise_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(perm_reg) |-> $past(perm_set))
        else $error("Permanent lock set without a write");

    copy_rise_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(copy_reg) |-> $past(copy_set))
        else $error("Copy flag set without a write");

    state_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !wr_word0 |=> ($stable(temp_reg) && $stable(crc_reg) && $stable(copy_reg) && $stable(perm_reg)))
        else $error("Writable bits moved without a write");

    rate_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !wr_ctrl |=> $stable(rate_reg))
        else $error("Rate select moved without a write");

    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !reg_rd |=> (reg_rdata == 32'h0))
        else $error("Read data not zero when idle");

    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && !(reg_addr inside {`CSD_OFS_WORD0, `CSD_OFS_WORD1, `CSD_OFS_WORD2, `CSD_OFS_WORD3,
            `CSD_OFS_CTRL, `CSD_OFS_STAT})) |=> (reg_rdata == 32'h0))
        else $error("Unmapped read not zero");

    ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `CSD_OFS_CTRL) |=> (reg_rdata == {30'h0, $past(rate_reg)}))
        else $error("Control readback wrong");

    status_fixed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `CSD_OFS_STAT) |=> (reg_rdata[23:8] == 16'h8004))
        else $error("Sector count or speed multiple wrong");

    block_valid_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `CSD_OFS_STAT) |=> reg_rdata[3])
        else $error("Block code reported invalid");

    status_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `CSD_OFS_STAT)
            |=> (reg_rdata[2:0] == {$past(perm_reg), $past(copy_reg), $past(write_locked)}))
        else $error("Status lock bits wrong");

    done_follow_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cmd_valid |=> cmd_done)
        else $error("Command not answered");

    ok_quiet_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !cmd_valid |=> (!cmd_done && !cmd_ok))
        else $error("Answer without a command");

    ok_needs_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cmd_ok |-> cmd_done)
        else $error("Accept without done");

    erase_unlocked_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && cmd_erase && !write_locked) |=> cmd_ok)
        else $error("Unlocked erase refused");

    long_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && !cmd_erase && cmd_len > 12'h200) |=> !cmd_ok)
        else $error("Oversized write accepted");

    zero_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && !cmd_erase && cmd_len == 12'h000) |=> !cmd_ok)
        else $error("Empty write accepted");

    perm_refuse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_valid && perm_reg) |=> !cmd_ok)
        else $error("Permanently locked card accepted");

    temp_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_word0 && !reg_wdata[`CSD_BIT_TEMP] && !perm_reg && !perm_set) |=> !write_locked)
        else $error("Temporary lock not cleared");

endmodule

// ---- csd_cfg.svh ----
// Offsets, field positions and fixed values of the card data register bank
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH
`define CSD_OFS_WORD0      8'h00
`define CSD_OFS_WORD1      8'h04
`define CSD_OFS_WORD2      8'h08
`define CSD_OFS_WORD3      8'h0c
`define CSD_OFS_CTRL       8'h10
`define CSD_OFS_STAT       8'h14
`define CSD_BIT_COPY       14
`define CSD_BIT_PERM       13
`define CSD_BIT_TEMP       12
`define CSD_CRC_HI         7
`define CSD_CRC_LO         1
`define CSD_LAYOUT_V2      2'h1
`define CSD_ACCESS_TIME    8'h0e
`define CSD_ACCESS_CYCLES  8'h00
`define CSD_RATE_DEFAULT   8'h32
`define CSD_RATE_HIGH      8'h5a
`define CSD_RATE_FAST      8'h0b
`define CSD_RATE_FASTEST   8'h2b
`define CSD_CMD_CLASSES    12'h5b5
`define CSD_READ_BLK_CODE  4'h9
`define CSD_WRITE_BLK_CODE 4'h9
`define CSD_SMALL_WRITE    1'h0
`define CSD_SINGLE_ERASE   1'h1
`define CSD_SECTOR_CODE    7'h7f
`define CSD_GROUP_CODE     7'h00
`define CSD_GROUP_ALLOWED  1'h0
`define CSD_SPEED_CODE     3'h2
`define CSD_FORMAT_FAMILY  1'h0
`define CSD_FORMAT_CODE    2'h0
`define CSD_DEVICE_SIZE    22'h001010
`define CSD_DRIVER_STAGE   1'h0
`define CSD_READ_ONLY_CARD 1'h0
`define CSD_BLOCK_UNIT     12'h200
`define CSD_CRC_POLY       7'h09
`endif

// ---- csd_pkg.sv ----
// Types shared by the card data register bank
package csd_pkg;
    typedef enum logic [1:0] {
        CSD_RATE_25M  = 2'b00,
        CSD_RATE_50M  = 2'b01,
        CSD_RATE_100M = 2'b10,
        CSD_RATE_200M = 2'b11
    } csd_rate_t;
    typedef logic [127:0] csd_word_t;
endpackage

// ---- csd_host_model.sv ----
// Host side model: register port master, command requester, checksum
`timescale 1ns/1ps
module csd_host_model (
    // Clock
    input  wire logic        sys_clk,
    // Register port
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata,
    // Command gate
    output logic             cmd_valid,
    output logic             cmd_erase,
    output logic      [11:0] cmd_len,
    input  wire logic        cmd_done,
    input  wire logic        cmd_ok
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        cmd_valid = 1'b0;
        cmd_erase = 1'b0;
        cmd_len   = 12'h0;
    end
    // Released lines except cmd_erase show the inverse, not the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [31:0] z);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        // Data stand in the cycle after the strobe; taken at its closing edge
        @(posedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
        z = reg_rdata;
    endtask
    task automatic cmd(input logic er, input logic [11:0] len, output logic dn, output logic ok);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_erase <= er;
        cmd_len   <= len;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_len   <= ~len;
        @(posedge sys_clk);
        dn = cmd_done;
        ok = cmd_ok;
    endtask
    // Host recomputes the checksum over bits 127:8 on every change
    function automatic logic [6:0] crc7(input logic [119:0] m);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = m[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
endmodule

// ---- testbench.sv ----
// Self-checking bench for the card data register bank
`timescale 1ns/1ps
`include "csd_cfg.svh"
module testbench
    import csd_pkg::*;
;
    logic        sys_clk, arst_n, reg_wr, reg_rd, cmd_valid, cmd_erase, cmd_done, cmd_ok, write_locked;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, z;
    logic [11:0] cmd_len;
    csd_word_t   card_specific_data, exp_img;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [7:0]  rates [4] = '{8'h32, 8'h5a, 8'h0b, 8'h2b};
    csd_regbank dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd_erase(cmd_erase), .cmd_len(cmd_len), .cmd_done(cmd_done), .cmd_ok(cmd_ok),
        .card_specific_data(card_specific_data), .write_locked(write_locked));
    csd_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_erase(cmd_erase),
        .cmd_len(cmd_len), .cmd_done(cmd_done), .cmd_ok(cmd_ok));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Ceiling well above the fewer than two hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_img();
        for (int w = 0; w < 4; w++) begin
            host.rd(8'(4 * w), d, z);
            chk("word", exp_img[w * 32 +: 32], d);
            chk("rdata_idle", 32'h0, z);
            chk("image_port", exp_img[w * 32 +: 32], card_specific_data[w * 32 +: 32]);
        end
    endtask
    task automatic chk_cmd(input logic er, input logic [11:0] len, input logic e);
        logic dn, ok;
        host.cmd(er, len, dn, ok);
        chk("cmd_done", 32'h1, {31'h0, dn});
        chk("cmd_ok", {31'h0, e}, {31'h0, ok});
    endtask
    // Read-only bits are flipped in the write data so that any leak shows
    task automatic prog0(input logic cp, input logic pm, input logic tp);
        logic [31:0] wd;
        exp_img[14]  = exp_img[14] | cp;
        exp_img[13]  = exp_img[13] | pm;
        exp_img[12]  = tp;
        exp_img[7:1] = host.crc7(exp_img[127:8]);
        wd           = exp_img[31:0] ^ 32'hffff8f01;
        wd[14]       = cp;
        wd[13]       = pm;
        host.wr(8'h00, wd);
    endtask
    initial begin
        arst_n  = 1'b0;
        exp_img = {2'h1, 6'h00, 8'h0e, 8'h00, 8'h32, `CSD_CMD_CLASSES, 4'h9, 3'h0, 1'h0, 6'h00,
            `CSD_DEVICE_SIZE, 1'h0, 1'h1, 7'h7f, 7'h00, 1'h0, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00,
            1'h0, 3'h0, 2'h0, 2'h0, 7'h00, 1'h1};
        exp_img[7:1] = host.crc7(exp_img[127:8]);
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        chk_img();
        host.rd(8'h14, d, z);
        chk("status", 32'h00800408, d);
        host.rd(8'h20, d, z);
        chk("unmapped", 32'h0, d);
        chk_cmd(1'b0, 12'h200, 1'b1);
        chk_cmd(1'b0, 12'h000, 1'b0);
        chk_cmd(1'b0, 12'h001, 1'b0);
        chk_cmd(1'b0, 12'h1ff, 1'b0);
        chk_cmd(1'b0, 12'h400, 1'b0);
        chk_cmd(1'b1, 12'h000, 1'b1);
        host.wr(8'h04, 32'hffffffff);
        host.wr(8'h0c, 32'h0);
        prog0(1'b0, 1'b0, 1'b1);
        @(posedge sys_clk);
        chk("locked", 32'h1, {31'h0, write_locked});
        chk_cmd(1'b0, 12'h200, 1'b0);
        chk_cmd(1'b1, 12'h000, 1'b0);
        chk_img();
        prog0(1'b0, 1'b0, 1'b0);
        chk_cmd(1'b0, 12'h200, 1'b1);
        prog0(1'b1, 1'b0, 1'b0);
        prog0(1'b0, 1'b0, 1'b0);
        chk_img();
        for (int r = 0; r < 4; r++) begin
            host.wr(8'h10, 32'(r));
            host.rd(8'h0c, d, z);
            chk("rate", {exp_img[127:104], rates[r]}, d);
            host.rd(8'h10, d, z);
            chk("ctrl", 32'(r), d);
        end
        host.wr(8'h10, 32'h0);
        prog0(1'b0, 1'b1, 1'b0);
        prog0(1'b0, 1'b0, 1'b0);
        chk("locked", 32'h1, {31'h0, write_locked});
        chk_cmd(1'b0, 12'h200, 1'b0);
        chk_cmd(1'b1, 12'h000, 1'b0);
        host.rd(8'h14, d, z);
        chk("status", 32'h0080040f, d);
        chk_img();
        test_done();
    end
endmodule
